// ---- hdl/ppbs_port.sv ----
`timescale 1ns/10ps
`include "ppbs_defs.svh"

module ppbs_fifo #(
	parameter int W = `PPBS_AD_W,
	parameter int D = `PPBS_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic rdy_r, rdy_nxt, push, pop;

	assign in_ready = rdy_r;
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rp_r];

	always_comb begin
		push = in_valid && rdy_r;
		pop = out_valid && out_ready;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		rdy_nxt = cnt_nxt < DEPTH_C;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
		end
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule

// Behaviour
// R1: parity makes ones even over bus lines
// R2: address parity checked clock after address phase
// R3: write parity checked clock after transfer
// R4: read parity driven one clock after data
// R5: parity released one clock after address/data
// R6: park bus lines while idle and granted
// R7: transfer only when both ready signals low
// R8: read data stable while target ready asserted
// R9: command decoded at address phase
// R10: frame high marks final data phase
// R11: target ready held through wait states
// R12: target ready driven high before floating
module ppbs_port #(
	parameter int DEPTH = `PPBS_FIFO_DEPTH,
	parameter logic [3:0] CLAIM_HI = `PPBS_CLAIM_HI
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [31:0] ad_in,
	output logic [31:0] ad_out,
	output logic ad_oe,
	input wire logic [3:0] primary_cmd_byte_enables_in,
	output logic [3:0] primary_cmd_byte_enables_out,
	output logic primary_cmd_byte_enables_oe,
	input wire logic primary_parity_line_in,
	output logic primary_parity_line_out,
	output logic primary_parity_line_oe,
	input wire logic frame_n_in,
	input wire logic primary_initiator_ready_n,
	output logic primary_target_ready_n_out,
	output logic primary_target_ready_n_oe,
	input wire logic grant_n,
	input wire logic [31:0] fill_data,
	input wire logic fill_valid,
	output logic fill_ready,
	output logic [31:0] wr_word,
	output logic wr_valid,
	output logic addr_par_err,
	output logic data_par_err
);
	function automatic logic par_even(input logic [31:0] a, input logic [3:0] c);
		return ^{a, c};
	endfunction

	ppbs_pkg::ppbs_state_e st_r, st_nxt;
	logic is_rd_r, is_rd_nxt;
	logic [31:0] ad_out_r, ad_out_nxt, wr_word_r, wr_word_nxt;
	logic ad_oe_r, ad_oe_nxt, cbe_oe_r, cbe_oe_nxt;
	logic [3:0] cbe_out_r, cbe_out_nxt, cbe_seen;
	logic par_out_r, par_out_nxt, par_oe_r, par_oe_nxt;
	logic trdy_n_r, trdy_n_nxt, trdy_oe_r, trdy_oe_nxt;
	logic wr_valid_r, wr_valid_nxt, achk_r, achk_nxt, aexp_r, aexp_nxt;
	logic dchk_r, dchk_nxt, dexp_r, dexp_nxt, aerr_r, aerr_nxt, derr_r, derr_nxt;
	logic park, rd_pop, rd_valid, xfer, addr_exp;
	logic [31:0] rd_head;
	logic fill_rdy_w;

	ppbs_fifo #(.W(32), .D(DEPTH)) u_fifo (
		.clk(ref_clk),
		.reset_n(reset_n),
		.in_data(fill_data),
		.in_valid(fill_valid),
		.in_ready(fill_rdy_w),
		.out_data(rd_head),
		.out_valid(rd_valid),
		.out_ready(rd_pop)
	);

	assign fill_ready = fill_rdy_w;
	assign ad_out = ad_out_r;
	assign ad_oe = ad_oe_r;
	assign primary_cmd_byte_enables_out = cbe_out_r;
	assign primary_cmd_byte_enables_oe = cbe_oe_r;
	assign primary_parity_line_out = par_out_r;
	assign primary_parity_line_oe = par_oe_r;
	assign primary_target_ready_n_out = trdy_n_r;
	assign primary_target_ready_n_oe = trdy_oe_r;
	assign wr_word = wr_word_r;
	assign wr_valid = wr_valid_r;
	assign addr_par_err = aerr_r;
	assign data_par_err = derr_r;
	assign cbe_seen = cbe_oe_r ? cbe_out_r : primary_cmd_byte_enables_in;
	assign addr_exp = par_even(ad_in, primary_cmd_byte_enables_in);
	assign xfer = !trdy_n_r && !primary_initiator_ready_n; // R7

	always_comb begin
		park = !grant_n && frame_n_in && primary_initiator_ready_n;
		st_nxt = st_r;
		is_rd_nxt = is_rd_r;
		ad_out_nxt = ad_out_r;
		ad_oe_nxt = ad_oe_r;
		cbe_oe_nxt = 1'b0;
		cbe_out_nxt = `PPBS_PARK_CBE;
		trdy_n_nxt = trdy_n_r;
		trdy_oe_nxt = trdy_oe_r;
		wr_word_nxt = wr_word_r;
		wr_valid_nxt = 1'b0;
		achk_nxt = 1'b0;
		aexp_nxt = aexp_r;
		dchk_nxt = 1'b0;
		dexp_nxt = dexp_r;
		rd_pop = 1'b0;
		par_out_nxt = par_even(ad_out_r, cbe_seen); // R1 R4
		par_oe_nxt = ad_oe_r; // R5
		aerr_nxt = achk_r && (aexp_r != primary_parity_line_in); // R2
		derr_nxt = dchk_r && (dexp_r != primary_parity_line_in); // R3
		unique case (st_r)
			ppbs_pkg::ST_IDLE: begin
				trdy_oe_nxt = 1'b0;
				trdy_n_nxt = 1'b1;
				ad_oe_nxt = park; // R6
				cbe_oe_nxt = park;
				ad_out_nxt = `PPBS_PARK_AD;
				if (!frame_n_in) begin
					achk_nxt = 1'b1;
					aexp_nxt = addr_exp;
					ad_oe_nxt = 1'b0;
					cbe_oe_nxt = 1'b0;
					if (ad_in[31:28] == CLAIM_HI &&
						(primary_cmd_byte_enables_in == `PPBS_CMD_MEM_READ ||
						primary_cmd_byte_enables_in == `PPBS_CMD_MEM_WRITE)) begin // R9
						st_nxt = ppbs_pkg::ST_TURN;
						is_rd_nxt = primary_cmd_byte_enables_in == `PPBS_CMD_MEM_READ;
					end else begin
						st_nxt = ppbs_pkg::ST_SKIP;
					end
				end
			end
			ppbs_pkg::ST_SKIP: begin
				if (frame_n_in && primary_initiator_ready_n) begin
					st_nxt = ppbs_pkg::ST_IDLE;
				end
			end
			ppbs_pkg::ST_TURN: begin
				st_nxt = ppbs_pkg::ST_DATA;
				trdy_oe_nxt = 1'b1;
				ad_oe_nxt = is_rd_r;
				trdy_n_nxt = is_rd_r;
			end
			ppbs_pkg::ST_DATA: begin
				if (xfer) begin
					if (is_rd_r) begin
						rd_pop = 1'b1;
						trdy_n_nxt = 1'b1;
					end else begin
						wr_word_nxt = ad_in;
						wr_valid_nxt = 1'b1;
						dchk_nxt = 1'b1;
						dexp_nxt = addr_exp;
					end
					if (frame_n_in) begin // R10
						st_nxt = ppbs_pkg::ST_END;
						trdy_n_nxt = 1'b1;
					end
				end else if (frame_n_in && primary_initiator_ready_n) begin
					st_nxt = ppbs_pkg::ST_END;
					trdy_n_nxt = 1'b1;
				end else if (is_rd_r && trdy_n_r && rd_valid) begin // R8
					ad_out_nxt = rd_head;
					trdy_n_nxt = 1'b0;
				end
			end
			ppbs_pkg::ST_END: begin
				st_nxt = ppbs_pkg::ST_IDLE;
				trdy_oe_nxt = 1'b0; // R12
				ad_oe_nxt = 1'b0;
			end
			default: begin
				st_nxt = ppbs_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_r <= ppbs_pkg::ST_IDLE;
			is_rd_r <= 1'b0;
			ad_out_r <= 32'h0000_0000;
			ad_oe_r <= 1'b0;
			cbe_out_r <= 4'h0;
			cbe_oe_r <= 1'b0;
			par_out_r <= 1'b0;
			par_oe_r <= 1'b0;
			trdy_n_r <= 1'b1;
			trdy_oe_r <= 1'b0;
			wr_word_r <= 32'h0000_0000;
			wr_valid_r <= 1'b0;
			achk_r <= 1'b0;
			aexp_r <= 1'b0;
			dchk_r <= 1'b0;
			dexp_r <= 1'b0;
			aerr_r <= 1'b0;
			derr_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			is_rd_r <= is_rd_nxt;
			ad_out_r <= ad_out_nxt;
			ad_oe_r <= ad_oe_nxt;
			cbe_out_r <= cbe_out_nxt;
			cbe_oe_r <= cbe_oe_nxt;
			par_out_r <= par_out_nxt;
			par_oe_r <= par_oe_nxt;
			trdy_n_r <= trdy_n_nxt;
			trdy_oe_r <= trdy_oe_nxt;
			wr_word_r <= wr_word_nxt;
			wr_valid_r <= wr_valid_nxt;
			achk_r <= achk_nxt;
			aexp_r <= aexp_nxt;
			dchk_r <= dchk_nxt;
			dexp_r <= dexp_nxt;
			aerr_r <= aerr_nxt;
			derr_r <= derr_nxt;
		end
	end

	chk_par_even: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
		$rose(par_oe_r) |-> par_out_r == ^{$past(ad_out_r), $past(cbe_seen)})
		else $error("parity not even over driven lines");
	chk_addr_parity: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
		(st_r == ppbs_pkg::ST_IDLE && !frame_n_in) |-> ##2
		aerr_r == ($past(primary_parity_line_in) != $past(addr_exp, 2)))
		else $error("address parity flag wrong");
	chk_write_parity: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
		(st_r == ppbs_pkg::ST_DATA && !is_rd_r && xfer) |-> ##2
		derr_r == ($past(primary_parity_line_in) != $past(addr_exp, 2)))
		else $error("write data parity flag wrong");
	chk_read_par: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
		(st_r == ppbs_pkg::ST_DATA && is_rd_r && !trdy_n_r) |=>
		par_oe_r && par_out_r == ^{$past(ad_out_r), $past(primary_cmd_byte_enables_in)})
		else $error("read parity not valid after target ready");
	chk_par_release: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
		$fell(ad_oe_r) |-> par_oe_r ##1 !par_oe_r)
		else $error("parity release not one clock after data");
	chk_park_drive: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
		(st_r == ppbs_pkg::ST_IDLE && park && frame_n_in) |=>
		ad_oe_r && cbe_oe_r && ad_out_r == `PPBS_PARK_AD ##1 par_oe_r)
		else $error("bus not parked while granted");
	chk_write_take: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
		(st_r == ppbs_pkg::ST_DATA && !is_rd_r && xfer) |=>
		wr_valid_r && wr_word_r == $past(ad_in))
		else $error("write word not taken on transfer");
	chk_read_stable: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8 R11
		(st_r == ppbs_pkg::ST_DATA && !trdy_n_r && primary_initiator_ready_n && !frame_n_in)
		|=> !trdy_n_r && $stable(ad_out_r))
		else $error("read data or target ready moved in wait state");
	chk_final_phase: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
		(st_r == ppbs_pkg::ST_DATA && xfer && frame_n_in) |=>
		st_r == ppbs_pkg::ST_END ##1 st_r == ppbs_pkg::ST_IDLE)
		else $error("final phase did not end access");
	chk_sts_high: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
		$fell(trdy_oe_r) |-> $past(trdy_n_r) && $past(trdy_oe_r, 2))
		else $error("target ready floated without high cycle");
endmodule

// ---- inc/ppbs_defs.svh ----
`ifndef PPBS_DEFS_SVH
`define PPBS_DEFS_SVH
`define PPBS_AD_W 32
`define PPBS_CBE_W 4
`define PPBS_FIFO_DEPTH 16
`define PPBS_CMD_MEM_READ 4'h6
`define PPBS_CMD_MEM_WRITE 4'h7
`define PPBS_PARK_AD 32'h0000_0000
`define PPBS_PARK_CBE 4'h0
`define PPBS_CLAIM_HI 4'h1
`endif

// ---- inc/ppbs_pkg.sv ----
package ppbs_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TURN = 3'b001,
		ST_DATA = 3'b010,
		ST_END = 3'b011,
		ST_SKIP = 3'b100
	} ppbs_state_e;
endpackage

// ---- sim/ppbs_init_model.sv ----
`timescale 1ns/10ps
module ppbs_init_model (
	input wire logic clk,
	input wire logic trdy_n,
	input wire logic [31:0] ad_w,
	input wire logic par_w,
	output logic frame_n,
	output logic irdy_n,
	output logic [31:0] ad,
	output logic [3:0] cbe,
	output logic par
);
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		ad = 32'h0;
		cbe = 4'hF;
		par = 1'b1;
	end
	// one single-phase transfer; released lines show the inverse of their last value
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, wd, input logic bad,
		output logic [31:0] rd, output logic hit, output logic pok);
		hit = 1'b0;
		pok = 1'b0;
		@(negedge clk);
		frame_n = 1'b0;
		ad = a;
		cbe = cmd;
		@(negedge clk);
		frame_n = 1'b1;
		irdy_n = 1'b0;
		par = ^{a, cmd} ^ bad;
		ad = cmd[0] ? wd : ~a;
		cbe = 4'h0;
		for (int n = 0; n < 12 && !hit; n++) begin
			@(negedge clk);
			if (n == 0)
				par = cmd[0] ? ^wd ^ bad : ~par;
			hit = (trdy_n === 1'b0);
		end
		rd = ad_w;
		if (hit) begin
			@(negedge clk);
			pok = (par_w === ^{rd, cbe});
		end
		irdy_n = 1'b1;
		ad = ~ad;
		cbe = ~cbe;
		@(negedge clk);
		par = ~par;
	endtask
	// two-phase read with one initiator wait state while target ready is low
	task automatic burst(input logic [31:0] a, output logic [31:0] r0, r1, output logic ok);
		int w;
		w = 0;
		@(negedge clk);
		frame_n = 1'b0;
		ad = a;
		cbe = 4'h6;
		@(negedge clk);
		par = ^{a, 4'h6};
		ad = ~a;
		cbe = 4'h0;
		while (w < 12 && trdy_n !== 1'b0) begin
			@(negedge clk);
			w++;
		end
		@(negedge clk);
		r0 = ad_w;
		irdy_n = 1'b0;
		@(negedge clk);
		frame_n = 1'b1;
		while (w < 24 && trdy_n !== 1'b0) begin
			@(negedge clk);
			w++;
		end
		r1 = ad_w;
		ok = (w < 8);
		@(negedge clk);
		irdy_n = 1'b1;
		ad = ~ad;
		cbe = ~cbe;
		@(negedge clk);
		par = ~par;
	endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic grant_n = 1'b1;
	logic [31:0] fill_data = 32'h0;
	logic fill_valid = 1'b0;
	logic [31:0] ad_out, m_ad, wr_word, ad_w, rd;
	logic [3:0] cbe_out, m_cbe;
	logic ad_oe, cbe_oe, par_out, par_oe, trdy_out, trdy_oe, m_par, frame_n, irdy_n;
	logic fill_ready, wr_valid, addr_par_err, data_par_err, hit, pok;
	logic p_oe = 1'b0;
	logic p_toe = 1'b0;
	logic p_tn = 1'b1;
	int errors = 0;
	int compares = 0;
	int aerr_n = 0;
	int derr_n = 0;
	int wr_n = 0;
	wire [3:0] cbe_w = cbe_oe ? cbe_out : m_cbe;
	wire par_w = par_oe ? par_out : m_par;
	wire trdy_w = trdy_oe ? trdy_out : 1'b1;
	assign ad_w = ad_oe ? ad_out : m_ad;
	always #5 ref_clk = ~ref_clk;
	ppbs_port ppbs_port_i (.ref_clk(ref_clk), .reset_n(reset_n), .ad_in(ad_w),
		.ad_out(ad_out), .ad_oe(ad_oe), .primary_cmd_byte_enables_in(cbe_w),
		.primary_cmd_byte_enables_out(cbe_out), .primary_cmd_byte_enables_oe(cbe_oe),
		.primary_parity_line_in(par_w), .primary_parity_line_out(par_out),
		.primary_parity_line_oe(par_oe), .frame_n_in(frame_n),
		.primary_initiator_ready_n(irdy_n), .primary_target_ready_n_out(trdy_out),
		.primary_target_ready_n_oe(trdy_oe), .grant_n(grant_n), .fill_data(fill_data),
		.fill_valid(fill_valid), .fill_ready(fill_ready), .wr_word(wr_word),
		.wr_valid(wr_valid), .addr_par_err(addr_par_err), .data_par_err(data_par_err));
	ppbs_init_model ppbs_init_model_i (.clk(ref_clk), .trdy_n(trdy_w), .ad_w(ad_w),
		.par_w(par_w), .frame_n(frame_n), .irdy_n(irdy_n), .ad(m_ad), .cbe(m_cbe),
		.par(m_par));
	always @(posedge ref_clk) begin
		aerr_n <= aerr_n + (addr_par_err === 1'b1);
		derr_n <= derr_n + (data_par_err === 1'b1);
		wr_n <= wr_n + (wr_valid === 1'b1);
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	always @(negedge ref_clk) begin
		if (reset_n)
			chk("par_oe", {31'h0, p_oe}, {31'h0, par_oe});
		if (reset_n && p_toe && !trdy_oe)
			chk("trdy high before float", 32'h1, {31'h0, p_tn});
		p_oe = ad_oe;
		p_toe = trdy_oe;
		p_tn = trdy_out;
	end
	task automatic t_write(input logic bad, input logic [31:0] a, d, input int n);
		ppbs_init_model_i.xfer(4'h7, a, d, bad, rd, hit, pok);
		@(negedge ref_clk);
		chk("hit", 32'h1, {31'h0, hit});
		chk("wr_word", d, wr_word);
		chk("wr count", n, wr_n);
		chk("aerr", n - 1, aerr_n);
		chk("derr", n - 1, derr_n);
		$display("test write done");
	endtask
	task automatic t_skip();
		ppbs_init_model_i.xfer(4'h7, 32'h2000_0000, 32'h5, 1'b0, rd, hit, pok);
		chk("skip hit", 32'h0, {31'h0, hit});
		ppbs_init_model_i.xfer(4'h3, 32'h1000_0000, 32'h5, 1'b0, rd, hit, pok);
		chk("skip hit", 32'h0, {31'h0, hit});
		chk("wr count", 32'h2, wr_n);
		$display("test unclaimed done");
	endtask
	task automatic t_park();
		@(negedge ref_clk);
		grant_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("park oe", 32'h7, {29'h0, ad_oe, cbe_oe, par_oe});
		chk("park ad", 32'h0, ad_out);
		chk("park cbe par", 32'h0, {27'h0, cbe_out, par_out});
		grant_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		$display("test park done");
	endtask
	task automatic t_fifo();
		int n;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			@(negedge ref_clk);
			fill_valid = 1'b1;
			fill_data = 32'hC0DE_0000 + n;
			if (fill_ready === 1'b1)
				n++;
		end
		@(negedge ref_clk);
		fill_valid = 1'b0;
		chk("fill n", 32'h10, n);
		chk("fill_ready", 32'h0, {31'h0, fill_ready});
		for (int i = 0; i < 16; i++) begin
			ppbs_init_model_i.xfer(4'h6, 32'h1000_0100, 32'h0, 1'b0, rd, hit, pok);
			chk("read word", 32'hC0DE_0000 + i, rd);
			chk("read par", 32'h1, {31'h0, pok});
		end
		chk("fill_ready", 32'h1, {31'h0, fill_ready});
		$display("test read done");
	endtask
	task automatic t_burst();
		logic [31:0] r0, r1;
		logic ok;
		for (int i = 0; i < 2; i++) begin
			@(negedge ref_clk);
			fill_valid = 1'b1;
			fill_data = 32'hB0B0_0000 + i;
		end
		@(negedge ref_clk);
		fill_valid = 1'b0;
		ppbs_init_model_i.burst(32'h1000_0200, r0, r1, ok);
		chk("burst ok", 32'h1, {31'h0, ok});
		chk("burst word0", 32'hB0B0_0000, r0);
		chk("burst word1", 32'hB0B0_0001, r1);
		$display("test burst done");
	endtask
	task automatic close_out();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		close_out();
	end
	initial begin
		repeat (12) @(negedge ref_clk);
		reset_n = 1'b1;
		t_write(1'b0, 32'h1000_0040, 32'hA5C3_0F96, 1);
		t_write(1'b1, 32'h1FFF_FFFC, 32'h0123_4567, 2);
		t_skip();
		t_park();
		t_fifo();
		t_burst();
		close_out();
	end
endmodule
